// >>> design/rtc_params.svh
// rtc_params.svh: offsets, field positions and reset values of the rtc
// assumes it is included by bare name from every rtc design file except the package
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_ADR_W 6
`define RTC_DAT_W 16
`define RTC_WORDS 10

// device register byte offsets; word index is offset divided by four
`define RTC_OFS_CTRL_HI 6'h00
`define RTC_OFS_CTRL_LO 6'h04
`define RTC_OFS_PRL_HI 6'h08
`define RTC_OFS_PRL_LO 6'h0C
`define RTC_OFS_DIV_HI 6'h10
`define RTC_OFS_DIV_LO 6'h14
`define RTC_OFS_CNT_HI 6'h18
`define RTC_OFS_CNT_LO 6'h1C
`define RTC_OFS_ALR_HI 6'h20
`define RTC_OFS_ALR_LO 6'h24

`define RTC_IDX_PRL_HI 4'h2
`define RTC_IDX_PRL_LO 4'h3
`define RTC_IDX_CNT_HI 4'h6
`define RTC_IDX_CNT_LO 4'h7
`define RTC_IDX_ALR_HI 4'h8
`define RTC_IDX_ALR_LO 4'h9

// control low fields
`define RTC_BIT_DONE 5
`define RTC_BIT_CFG 4
`define RTC_BIT_GIR 3
// flag and enable positions; bits 0 to 2 shared by both control words, GLB in control high only
`define RTC_BIT_OVF 2
`define RTC_BIT_ALM 1
`define RTC_BIT_SEC 0
`define RTC_BIT_GLB 3

`define PRESCALER_RELOAD_RST 20'h08000
`define RTC_DIV_RST 20'h08000
`define COUNT_VALUE_RST 32'h00000000
`define ALARM_VALUE_RST 32'h00000000
`define COUNT_VALUE_MAX 32'hFFFFFFFF

// controller wishbone map
`define RTC_WB_CMD 8'h00
`define RTC_WB_WDATA 8'h04
`define RTC_WB_RDATA 8'h08
`define RTC_WB_STATUS 8'h0C
`define RTC_WB_CMD_WE 8

`endif

// >>> design/rtc_pkg.sv
// rtc_pkg: state types of the rtc device and its controller
// assumes nothing of its surroundings
package rtc_pkg;
  typedef enum logic [2:0] {
    RTC_XF_IDLE = 3'b001,
    RTC_XF_WAIT1 = 3'b010,
    RTC_XF_WAIT2 = 3'b100
  } rtc_xfer_t;

  typedef enum logic [3:0] {
    RTC_H_IDLE = 4'b0001,
    RTC_H_POLL = 4'b0010,
    RTC_H_GAP = 4'b0100,
    RTC_H_XFER = 4'b1000
  } rtc_host_t;
endpackage : rtc_pkg

// >>> design/rtc_link_if.sv
// rtc_link_if: register link between the rtc device and its controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "rtc_params.svh"
interface rtc_link_if;
  logic req;
  logic we;
  logic [`RTC_ADR_W-1:0] addr;
  logic [`RTC_DAT_W-1:0] wdata;
  logic [`RTC_DAT_W-1:0] rdata;
  logic ack;
  logic irq_global;
  logic irq_sec;
  logic irq_alarm;
  logic irq_ovf;

  modport dev (
    input req, we, addr, wdata,
    output rdata, ack, irq_global, irq_sec, irq_alarm, irq_ovf
  );
  modport ctl (
    output req, we, addr, wdata,
    input rdata, ack, irq_global, irq_sec, irq_alarm, irq_ovf
  );
endinterface : rtc_link_if

// >>> design/rtc_device.sv
// rtc_device: prescaler, 32-bit counter, alarm and flags of the rtc
// assumes the slow clock arrives as a level at most a quarter of i_clock
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "rtc_params.svh"

// What this block does
// (RL1) 20-bit prescaler divides slow clock
// (RL2) tick period programmable up to one second
// (RL3) 32-bit loadable counter advances each tick
// (RL4) second request every tick, gated by enable
// (RL5) alarm request when counter equals alarm
// (RL6) overflow request when counter wraps
// (RL7) global request is OR of three
// (RL8) slow clock at most quarter bus clock
// (RL9) 16-bit registers on bus clock
// (RL10) bus isolated when main power off
// (RL11) system reset clears all but core
// (RL12) power-on reset alone clears core registers
// (RL13) counting starts at power-on, enables cleared
// (RL14) software clears stale flags before enabling
// (RL15) reload, counter, alarm writes need config
// (RL16) writes rejected while write done low
// (RL17) software follows poll, set, write, clear
// (RL18) transfer on config clear, two slow cycles
// (RL19) wait one slow period after wakeup
// (RL20) flags set by hardware, cleared writing zero
// (RL21) each request gated by own enable
// (RL22) divider reloads each tick, readable live
// (RL23) counter half write restarts prescaler
// (RL24) slow clock and transfers properly synchronised
module rtc_device
  import rtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_sys_arst_n,
  input wire logic i_slow_clock,
  input wire logic i_main_power_ok,
  rtc_link_if.dev link,
  output logic o_time_base_tick,
  output logic [31:0] o_count_value
);
  logic slow_s1;
  logic slow_s2;
  logic slow_s3;
  logic slow_edge;
  logic [19:0] prescaler_reload;
  logic [19:0] divider;
  logic [31:0] count_value;
  logic [31:0] alarm_value;
  logic [19:0] next_reload;
  logic [31:0] next_count;
  logic [31:0] next_alarm;
  logic time_base_tick;
  logic [2:0] event_set;
  logic [2:0] flags;
  logic [3:0] enables;
  logic config_flag;
  logic write_done_flag;
  logic [`RTC_DAT_W-1:0] stage [0:`RTC_WORDS-1];
  logic [`RTC_WORDS-1:0] pend;
  rtc_xfer_t xfer_state;
  logic apply;
  logic access;
  logic write_ok;
  logic [3:0] word_idx;
  logic cfg_target;
  logic [`RTC_DAT_W-1:0] read_val;
  logic ack;
  logic [`RTC_DAT_W-1:0] rdata;

  // slow clock is a plain level; edges are taken from the second and third stages
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= i_slow_clock; // RL24
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end
  // a quarter-rate slow clock leaves room for the synchroniser
  assign slow_edge = slow_s2 & ~slow_s3; // RL8

  assign time_base_tick = slow_edge && (divider == 20'h00000) && !apply; // RL1
  assign apply = (xfer_state == RTC_XF_WAIT2) && slow_edge;

  // staged halves override the live ones only where written
  always_comb begin
    next_reload = prescaler_reload;
    next_count = count_value;
    next_alarm = alarm_value;
    if (pend[`RTC_IDX_PRL_HI]) begin
      next_reload[19:16] = stage[`RTC_IDX_PRL_HI][3:0];
    end
    if (pend[`RTC_IDX_PRL_LO]) begin
      next_reload[15:0] = stage[`RTC_IDX_PRL_LO];
    end
    if (pend[`RTC_IDX_CNT_HI]) begin
      next_count[31:16] = stage[`RTC_IDX_CNT_HI];
    end
    if (pend[`RTC_IDX_CNT_LO]) begin
      next_count[15:0] = stage[`RTC_IDX_CNT_LO];
    end
    if (pend[`RTC_IDX_ALR_HI]) begin
      next_alarm[31:16] = stage[`RTC_IDX_ALR_HI];
    end
    if (pend[`RTC_IDX_ALR_LO]) begin
      next_alarm[15:0] = stage[`RTC_IDX_ALR_LO];
    end
  end

  // core chain: only power-on reset touches it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prescaler_reload <= `PRESCALER_RELOAD_RST; // RL12
      divider <= `RTC_DIV_RST;
      count_value <= `COUNT_VALUE_RST;
      alarm_value <= `ALARM_VALUE_RST;
    end else if (apply) begin
      prescaler_reload <= next_reload; // RL2
      count_value <= next_count;
      alarm_value <= next_alarm;
      if (pend[`RTC_IDX_PRL_HI] || pend[`RTC_IDX_PRL_LO] ||
          pend[`RTC_IDX_CNT_HI] || pend[`RTC_IDX_CNT_LO]) begin
        divider <= next_reload; // RL23
      end
    end else if (slow_edge) begin
      // free running from power-on onward
      if (divider == 20'h00000) begin
        divider <= prescaler_reload; // RL22
        count_value <= count_value + 32'h00000001; // RL3 RL13
      end else begin
        divider <= divider - 20'h00001;
      end
    end
  end

  assign event_set[`RTC_BIT_SEC] = time_base_tick; // RL4
  assign event_set[`RTC_BIT_ALM] = time_base_tick &&
    (count_value + 32'h00000001 == alarm_value); // RL5
  assign event_set[`RTC_BIT_OVF] = time_base_tick &&
    (count_value == `COUNT_VALUE_MAX); // RL6

  assign access = link.req & ~ack & i_main_power_ok; // RL10
  assign word_idx = link.addr[5:2];
  assign write_ok = access & link.we & write_done_flag; // RL16
  assign cfg_target = (word_idx == `RTC_IDX_PRL_HI) ||
    (word_idx == `RTC_IDX_PRL_LO) || (word_idx == `RTC_IDX_CNT_HI) ||
    (word_idx == `RTC_IDX_CNT_LO) || (word_idx == `RTC_IDX_ALR_HI) ||
    (word_idx == `RTC_IDX_ALR_LO);

  // set beats a clear landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      always_ff @(posedge i_clock or negedge i_sys_arst_n) begin
        if (!i_sys_arst_n) begin
          flags[gi] <= 1'b0; // RL11
        end else if (event_set[gi]) begin
          flags[gi] <= 1'b1; // RL20
        end else if (write_ok && link.addr == `RTC_OFS_CTRL_LO &&
                     !link.wdata[gi]) begin
          flags[gi] <= 1'b0; // RL20
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_sys_arst_n) begin
    if (!i_sys_arst_n) begin
      enables <= 4'h0; // RL21 RL13
      config_flag <= 1'b0;
    end else if (write_ok) begin
      if (link.addr == `RTC_OFS_CTRL_HI) begin
        enables <= link.wdata[3:0];
      end
      if (link.addr == `RTC_OFS_CTRL_LO) begin
        config_flag <= link.wdata[`RTC_BIT_CFG];
      end
    end
  end

  // staging holds software values until the slow side takes them
  always_ff @(posedge i_clock or negedge i_sys_arst_n) begin
    if (!i_sys_arst_n) begin
      pend <= '0;
    end else if (apply) begin
      pend <= '0;
    end else if (write_ok && config_flag && cfg_target) begin
      pend[word_idx] <= 1'b1; // RL15
    end
  end

  always_ff @(posedge i_clock) begin
    if (write_ok && config_flag && cfg_target) begin
      stage[word_idx] <= link.wdata; // RL15
    end
  end

  // leaving config mode starts the update; two slow edges pass
  always_ff @(posedge i_clock or negedge i_sys_arst_n) begin
    if (!i_sys_arst_n) begin
      xfer_state <= RTC_XF_IDLE;
    end else begin
      case (xfer_state)
        RTC_XF_IDLE: begin
          if (write_ok && link.addr == `RTC_OFS_CTRL_LO && config_flag &&
              !link.wdata[`RTC_BIT_CFG]) begin
            xfer_state <= RTC_XF_WAIT1; // RL18
          end
        end
        RTC_XF_WAIT1: begin
          if (slow_edge) begin
            xfer_state <= RTC_XF_WAIT2; // RL18
          end
        end
        RTC_XF_WAIT2: begin
          if (slow_edge) begin
            xfer_state <= RTC_XF_IDLE;
          end
        end
        default: begin
          xfer_state <= RTC_XF_IDLE;
        end
      endcase
    end
  end
  assign write_done_flag = (xfer_state == RTC_XF_IDLE); // RL18

  always_comb begin
    read_val = '0;
    case (link.addr)
      `RTC_OFS_CTRL_HI: read_val[3:0] = enables;
      `RTC_OFS_CTRL_LO: read_val[5:0] = {write_done_flag, config_flag,
                                         |flags, flags};
      `RTC_OFS_DIV_HI: read_val[3:0] = divider[19:16]; // RL22
      `RTC_OFS_DIV_LO: read_val = divider[15:0];
      `RTC_OFS_CNT_HI: read_val = count_value[31:16];
      `RTC_OFS_CNT_LO: read_val = count_value[15:0];
      `RTC_OFS_ALR_HI: read_val = alarm_value[31:16];
      `RTC_OFS_ALR_LO: read_val = alarm_value[15:0];
      default: read_val = '0;
    endcase
  end

  // one answer per request; writes that are refused still answer
  always_ff @(posedge i_clock or negedge i_sys_arst_n) begin
    if (!i_sys_arst_n) begin
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= access; // RL9
      if (access && !link.we) begin
        rdata <= read_val;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_time_base_tick <= 1'b0;
    end else begin
      o_time_base_tick <= time_base_tick;
    end
  end

  assign link.ack = ack;
  assign link.rdata = rdata;
  assign link.irq_sec = flags[`RTC_BIT_SEC] & enables[`RTC_BIT_SEC]; // RL21
  assign link.irq_alarm = flags[`RTC_BIT_ALM] & enables[`RTC_BIT_ALM];
  assign link.irq_ovf = flags[`RTC_BIT_OVF] & enables[`RTC_BIT_OVF];
  assign link.irq_global = (|flags) & enables[`RTC_BIT_GLB]; // RL7
  assign o_count_value = count_value;
endmodule : rtc_device

// >>> design/rtc_host.sv
// rtc_host: wishbone-driven controller that walks the rtc register link
// assumes a classic wishbone master and the device on the same clock
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_host
  import rtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  rtc_link_if.ctl link
);
  rtc_host_t state;
  logic wb_access;
  logic wb_write;
  logic start;
  logic [`RTC_ADR_W-1:0] cmd_addr;
  logic cmd_we;
  logic [`RTC_DAT_W-1:0] cmd_wdata;
  logic [`RTC_DAT_W-1:0] read_back;
  logic poll_ok;
  logic req;
  logic we;
  logic [`RTC_ADR_W-1:0] addr;
  logic [`RTC_DAT_W-1:0] wdata;

  assign wb_access = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_write = wb_access & i_wb_we;
  assign start = wb_write && i_wb_adr == `RTC_WB_CMD && i_wb_sel[0] &&
    state == RTC_H_IDLE;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_addr <= '0;
      cmd_we <= 1'b0;
      cmd_wdata <= '0;
    end else begin
      if (start) begin
        cmd_addr <= i_wb_dat[`RTC_ADR_W-1:0];
        cmd_we <= i_wb_dat[`RTC_WB_CMD_WE];
      end
      if (wb_write && i_wb_adr == `RTC_WB_WDATA) begin
        if (i_wb_sel[0]) begin
          cmd_wdata[7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          cmd_wdata[15:8] <= i_wb_dat[15:8];
        end
      end
    end
  end

  // every write waits for the device to report its last one done
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= RTC_H_IDLE;
      req <= 1'b0;
      we <= 1'b0;
      addr <= '0;
      wdata <= '0;
      poll_ok <= 1'b0;
      read_back <= '0;
    end else begin
      case (state)
        RTC_H_IDLE: begin
          if (start) begin
            req <= 1'b1;
            if (i_wb_dat[`RTC_WB_CMD_WE]) begin
              we <= 1'b0;
              addr <= `RTC_OFS_CTRL_LO; // RL16
              state <= RTC_H_POLL;
            end else begin
              we <= 1'b0;
              addr <= i_wb_dat[`RTC_ADR_W-1:0];
              state <= RTC_H_XFER;
            end
          end
        end
        RTC_H_POLL: begin
          if (link.ack) begin
            req <= 1'b0;
            poll_ok <= link.rdata[`RTC_BIT_DONE]; // RL17
            state <= RTC_H_GAP;
          end
        end
        RTC_H_GAP: begin
          req <= 1'b1;
          if (poll_ok) begin
            we <= 1'b1;
            addr <= cmd_addr;
            wdata <= cmd_wdata;
            state <= RTC_H_XFER;
          end else begin
            state <= RTC_H_POLL;
          end
        end
        RTC_H_XFER: begin
          if (link.ack) begin
            req <= 1'b0;
            we <= 1'b0;
            if (!cmd_we) begin
              read_back <= link.rdata;
            end
            state <= RTC_H_IDLE;
          end
        end
        default: begin
          state <= RTC_H_IDLE;
          req <= 1'b0;
        end
      endcase
    end
  end

  // unmapped addresses read zero and still answer
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_access;
      o_wb_dat <= '0;
      if (wb_access && !i_wb_we) begin
        case (i_wb_adr)
          `RTC_WB_CMD: o_wb_dat <= {23'h000000, cmd_we, 2'h0, cmd_addr};
          `RTC_WB_WDATA: o_wb_dat <= {16'h0000, cmd_wdata};
          `RTC_WB_RDATA: o_wb_dat <= {16'h0000, read_back};
          `RTC_WB_STATUS: o_wb_dat <= {27'h0000000, link.irq_global,
            link.irq_ovf, link.irq_alarm, link.irq_sec,
            state != RTC_H_IDLE};
          default: o_wb_dat <= '0;
        endcase
      end
    end
  end

  assign link.req = req;
  assign link.we = we;
  assign link.addr = addr;
  assign link.wdata = wdata;
endmodule : rtc_host

// >>> test/rtc_link_chk.sv
// rtc_link_chk: handshake and readback checks on the rtc register link
// assumes the reset input is the and of both resets, one clock for all
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_link_chk (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_main_power_ok,
  input wire logic req,
  input wire logic we,
  input wire logic [`RTC_ADR_W-1:0] addr,
  input wire logic [`RTC_DAT_W-1:0] wdata,
  input wire logic [`RTC_DAT_W-1:0] rdata,
  input wire logic ack,
  input wire logic irq_global,
  input wire logic irq_sec,
  input wire logic irq_alarm,
  input wire logic irq_ovf
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a pending request");
  ack_prompt_a: assert property (
    req && !ack && i_main_power_ok |=> ack)
    else $error("request not answered next cycle");
  ack_single_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  req_release_a: assert property (ack |=> !req)
    else $error("request kept after ack");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr)
    && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  rdata_source_a: assert property ($changed(rdata) |-> ack && !we)
    else $error("read data moved outside a read answer");
  status_or_a: assert property (
    ack && !we && addr == `RTC_OFS_CTRL_LO
    |-> rdata[3] == |rdata[2:0] && rdata[15:6] == 10'h000)
    else $error("summary request bit not the or of flags");
  zero_read_a: assert property (ack && !we && (addr > `RTC_OFS_ALR_LO
    || addr == `RTC_OFS_PRL_HI || addr == `RTC_OFS_PRL_LO)
    |-> rdata == 16'h0000)
    else $error("write-only or unused word read non-zero");
  flag_clear_a: assert property (
    $fell(irq_sec) || $fell(irq_alarm) || $fell(irq_ovf)
    |-> (ack && we) || $past(ack && we))
    else $error("request line fell without a write");
endmodule : rtc_link_chk

// >>> test/testbench.sv
// testbench: drives the rtc controller over wishbone and the core pins
// assumes rtc_host and rtc_device meet through rtc_link_if on one clock
`timescale 1ns/1ps
`include "rtc_params.svh"
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module testbench;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sys_arst_n = 1'b1;
  logic i_slow_clock = 1'b0;
  logic i_main_power_ok = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [3:0] sdiv = 4'h0;
  logic wb_ack, tick;
  logic [31:0] wb_rdat, cnt_val, wbq, m_cnt, m_alr;
  logic [15:0] rd;
  logic [2:0] m_flg = 3'h0;
  logic [3:0] m_en = 4'h0;
  int error_cnt, cmp_count, cyc_n, last_tick, rl, pend, n;
  logic [5:0] ra [7] = '{`RTC_OFS_CTRL_HI, `RTC_OFS_CTRL_LO,
    `RTC_OFS_PRL_HI, `RTC_OFS_PRL_LO, `RTC_OFS_DIV_HI, `RTC_OFS_CNT_HI,
    `RTC_OFS_ALR_LO};
  logic [15:0] re [7] = '{16'h0000, 16'h0020, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  rtc_link_if link ();
  rtc_host i_rtc_host (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat), .i_wb_sel(4'hF),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .link(link));
  rtc_device i_rtc_device (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_sys_arst_n(i_sys_arst_n), .i_slow_clock(i_slow_clock),
    .i_main_power_ok(i_main_power_ok), .link(link),
    .o_time_base_tick(tick), .o_count_value(cnt_val));
  rtc_link_chk i_rtc_link_chk (.i_clock(i_clock),
    .i_arst_n(i_arst_n & i_sys_arst_n), .i_main_power_ok(i_main_power_ok),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .irq_global(link.irq_global),
    .irq_sec(link.irq_sec), .irq_alarm(link.irq_alarm),
    .irq_ovf(link.irq_ovf));

  initial begin
    forever #4 i_clock = ~i_clock;
  end

  // slow clock of 16 bus cycles, well inside the quarter-rate limit
  always @(posedge i_clock) begin
    sdiv <= sdiv + 4'h1;
    i_slow_clock <= sdiv[3];
  end

  // reference core: advance on each tick, compare one cycle later
  always @(posedge i_clock) begin
    cyc_n++;
    if (pend) begin
      `CHK("count", m_cnt, cnt_val)
      `CHK("irq_sec", m_flg[0] & m_en[0], link.irq_sec)
      `CHK("irq_alarm", m_flg[1] & m_en[1], link.irq_alarm)
      `CHK("irq_ovf", m_flg[2] & m_en[2], link.irq_ovf)
      `CHK("irq_global", (|m_flg) & m_en[3], link.irq_global)
      pend = 0;
    end
    if (tick === 1'b1) begin
      if (last_tick != 0) `CHK("tick gap", (rl + 1) * 16, cyc_n - last_tick)
      last_tick = cyc_n;
      m_flg[2] = m_flg[2] | (m_cnt == 32'hFFFFFFFF);
      m_cnt = m_cnt + 32'h1;
      m_flg[0] = 1'b1;
      m_flg[1] = m_flg[1] | (m_cnt == m_alr);
      pend = 1;
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge i_clock);
    end while (wb_ack !== 1'b1);
    wbq = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      wb(1'b0, `RTC_WB_STATUS, 32'h00000000);
      k++;
    end while (wbq[0] !== 1'b0 && k < 200);
    if (wbq[0] !== 1'b0) error_cnt++;
  endtask : wait_idle

  task automatic lk(input logic we, input logic [5:0] a, input logic [15:0] d);
    wb(1'b1, `RTC_WB_WDATA, {16'h0000, d});
    wb(1'b1, `RTC_WB_CMD, {23'h000000, we, 2'b00, a});
    wait_idle();
    if (!we) begin
      wb(1'b0, `RTC_WB_RDATA, 32'h00000000);
      rd = wbq[15:0];
    end
  endtask : lk

  task automatic tk(input int c);
    repeat (c) begin
      n = 0;
      do begin
        @(posedge i_clock);
        n++;
      end while (tick !== 1'b1 && n < 2000);
      if (tick !== 1'b1) error_cnt++;
    end
  endtask : tk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial begin
    repeat (40000) @(posedge i_clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    m_cnt = 32'h00000000;
    m_alr = 32'h00000001;
    void'($urandom(55137));
    repeat (8) @(posedge i_clock);
    i_arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      lk(1'b0, ra[i], 16'h0000);
      `CHK("reset value", re[i], rd)
    end
    wb(1'b0, 8'h10, 32'h00000000);
    `CHK("unmapped", 32'h00000000, wbq)
    lk(1'b1, `RTC_OFS_CNT_LO, 16'h1234);
    lk(1'b0, `RTC_OFS_CNT_LO, 16'h0000);
    `CHK("counter outside config", 16'h0000, rd)
    $display("test reset and refusal done");
    rl = 3 + $urandom_range(3);
    m_cnt = 32'hFFFFFFFE - $urandom_range(1);
    lk(1'b1, `RTC_OFS_CTRL_LO, 16'h0010);
    lk(1'b1, `RTC_OFS_PRL_HI, 16'h0000);
    lk(1'b1, `RTC_OFS_PRL_LO, rl[15:0]);
    lk(1'b1, `RTC_OFS_CNT_HI, m_cnt[31:16]);
    lk(1'b1, `RTC_OFS_CNT_LO, m_cnt[15:0]);
    lk(1'b1, `RTC_OFS_ALR_HI, m_alr[31:16]);
    lk(1'b1, `RTC_OFS_ALR_LO, m_alr[15:0]);
    last_tick = 0;
    lk(1'b1, `RTC_OFS_CTRL_LO, 16'h0000);
    lk(1'b0, `RTC_OFS_CTRL_LO, 16'h0000);
    `CHK("done during update", 1'b0, rd[5])
    n = 0;
    while (rd[5] !== 1'b1 && n < 20) begin
      lk(1'b0, `RTC_OFS_CTRL_LO, 16'h0000);
      n++;
    end
    if (rd[5] !== 1'b1) error_cnt++;
    lk(1'b0, `RTC_OFS_CNT_LO, 16'h0000);
    `CHK("loaded count", m_cnt[15:0], rd)
    $display("test configuration done");
    // flags pile up while masked, then each enable alone
    tk(4);
    for (int e = 0; e < 4; e++) begin
      tk(1);
      lk(1'b1, `RTC_OFS_CTRL_HI, 16'h0001 << e);
      m_en = 4'h1 << e;
      tk(1);
    end
    tk(1);
    lk(1'b1, `RTC_OFS_CTRL_LO, 16'h0007);
    lk(1'b0, `RTC_OFS_CTRL_LO, 16'h0000);
    `CHK("flags kept", 16'h002F, rd)
    wb(1'b0, `RTC_WB_STATUS, 32'h00000000);
    rd = {11'h000, (|m_flg) & m_en[3], m_flg & m_en[2:0], 1'b0};
    `CHK("status irqs", rd, wbq[15:0])
    tk(1);
    lk(1'b1, `RTC_OFS_CTRL_LO, 16'h0000);
    m_flg = 3'h0;
    lk(1'b0, `RTC_OFS_CTRL_LO, 16'h0000);
    `CHK("flags cleared", 16'h0020, rd)
    tk(2);
    $display("test flags and enables done");
    tk(1);
    // let the check of this tick see the flags before they are wiped
    @(posedge i_clock);
    i_sys_arst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_sys_arst_n <= 1'b1;
    m_flg = 3'h0;
    m_en = 4'h0;
    lk(1'b0, `RTC_OFS_CTRL_HI, 16'h0000);
    `CHK("enables after sys reset", 16'h0000, rd)
    lk(1'b0, `RTC_OFS_ALR_LO, 16'h0000);
    `CHK("alarm after sys reset", m_alr[15:0], rd)
    tk(2);
    $display("test system reset done");
    i_main_power_ok <= 1'b0;
    wb(1'b1, `RTC_WB_CMD, {23'h000000, 1'b0, 2'b00, `RTC_OFS_CNT_LO});
    tk(2);
    wb(1'b0, `RTC_WB_STATUS, 32'h00000000);
    `CHK("stalled while off", 1'b1, wbq[0])
    i_main_power_ok <= 1'b1;
    wait_idle();
    wb(1'b0, `RTC_WB_RDATA, 32'h00000000);
    `CHK("count after power", m_cnt[15:0], wbq[15:0])
    repeat (16) @(posedge i_clock);
    lk(1'b0, `RTC_OFS_CNT_LO, 16'h0000);
    `CHK("count after wakeup", m_cnt[15:0], rd)
    $display("test power isolation done");
    end_sim();
  end
endmodule : testbench
